/* File: rtc_pkg.sv */
package rtc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFF_MASK = 7'h1C;
  localparam logic [6:0] OFF_RAW = 7'h20;
  localparam logic [6:0] OFF_MASKED = 7'h24;
  localparam logic [6:0] OFF_CLEAR = 7'h28;
  localparam logic [6:0] OFF_DATA = 7'h2C;
  localparam logic [6:0] OFF_CTRL = 7'h30;
  localparam logic [6:0] OFF_LOAD1 = 7'h34;
  localparam logic [6:0] OFF_LOAD2 = 7'h38;
  localparam logic [6:0] OFF_PAT0 = 7'h3C;
  localparam logic [6:0] OFF_PAT3 = 7'h48;
  localparam logic [6:0] OFF_IRQ_NUM = 7'h4C;
  localparam logic [6:0] PAT_STEP = 7'h04;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WATCH_BIT = 0;
  localparam int TIMER_BIT = 1;
  localparam int CTL_SHOT = 0;
  localparam int CTL_EN = 1;
  localparam int CTL_SELF = 2;
  localparam int CTL_LEN_LO = 4;
  localparam int CTL_LEN_HI = 10;
  localparam int CTL_CLKSEL = 11;
  localparam int CTL_GATE = 12;
  localparam int PAT_REGS = 4;
  localparam int PAT_BITS = 128;
  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_WMASK = 32'h0000_1FF7;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0FFF_FFFF;
  localparam logic [31:0] LOAD_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_NUM_RST = 32'h0000_0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // bus handshake states
  typedef enum logic {RTC_BUS_IDLE, RTC_BUS_ANSWER} rtc_bus_t;
endpackage : rtc_pkg

/* File: rtc_tick_if.sv */
`timescale 1ns/1ps
// slow-clock tick request and answer between control and tick logic
interface rtc_tick_if;
  logic clkSel;
  logic gateBypass;
  logic running;
  logic tick;
  modport ctl (output clkSel, output gateBypass, output running, input tick);
  modport gen (input clkSel, input gateBypass, input running, output tick);
endinterface : rtc_tick_if

/* File: rtc_tick_gen.sv */
`timescale 1ns/1ps
module rtc_tick_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slowRefClock,
  input wire logic trimmedClock,
  rtc_tick_if.gen tk
);
  logic [1:0] pinIn;
  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  logic [1:0] hist_reg;
  logic [1:0] rise;
  logic tick_reg;

  assign pinIn = {trimmedClock, slowRefClock};

  // ----------------------------------------------------------------
  // two-flop synchronisers, edge taken only after the second stage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_src
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        syncA_reg[i] <= 1'b0;
        syncB_reg[i] <= 1'b0;
        hist_reg[i] <= 1'b0;
      end else begin
        syncA_reg[i] <= pinIn[i];
        syncB_reg[i] <= syncA_reg[i];
        hist_reg[i] <= syncB_reg[i];
      end
    end
    assign rise[i] = syncB_reg[i] & ~hist_reg[i];
  end

  // gated tick: with gating active the tick only flows while counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= rise[tk.clkSel] & (tk.gateBypass | tk.running);
    end
  end

  assign tk.tick = tick_reg;
endmodule : rtc_tick_gen

/* File: rtc_timer_irq_control.sv */
`timescale 1ns/1ps
module rtc_timer_irq_control #(
  parameter int PAT_BITS = 128
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  input wire logic [3:0] avm_byteenable,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic slowRefClock,
  input wire logic trimmedClock,
  input wire logic watchEvent,
  output logic watchIrqOut,
  output logic timerIrqOut
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PAT_BITS != rtc_pkg::PAT_BITS) begin : g_bad
    $error("pattern width must match the four pattern registers");
  end

  rtc_pkg::rtc_bus_t state_reg;
  logic wait_reg;
  logic [31:0] rdData_reg;
  logic [31:0] rdValue;
  logic [1:0] mask_reg;
  logic [1:0] raw_reg;
  logic [31:0] ctl_reg;
  logic [31:0] count_reg;
  logic [31:0] load1_reg;
  logic [31:0] load2_reg;
  logic [31:0] irqNum_reg;
  logic [31:0] pat_reg [rtc_pkg::PAT_REGS];
  logic [PAT_BITS-1:0] patFlat;
  logic [6:0] ptr_reg;
  logic [6:0] ptr_next;
  logic [6:0] patLen;
  logic watchOut_reg;
  logic timerOut_reg;
  logic wrAcc;
  logic loadHit;
  logic patHit;
  logic [31:0] wrMerged;
  logic [1:0] clrHit;
  logic timerOn;
  logic timerZero;
  logic [31:0] reloadValue;

  rtc_tick_if tickIf ();

  // ----------------------------------------------------------------
  // tick generation
  // ----------------------------------------------------------------
  assign tickIf.clkSel = ctl_reg[rtc_pkg::CTL_CLKSEL];
  assign tickIf.gateBypass = ctl_reg[rtc_pkg::CTL_GATE];
  assign tickIf.running = timerOn;

  rtc_tick_gen u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .slowRefClock(slowRefClock),
    .trimmedClock(trimmedClock),
    .tk(tickIf.gen)
  );

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait cycle: data is read on the first edge, then presented
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= rtc_pkg::RTC_BUS_IDLE;
      wait_reg <= 1'b1;
      rdData_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        rtc_pkg::RTC_BUS_IDLE: begin
          if (avm_read || avm_write) begin
            state_reg <= rtc_pkg::RTC_BUS_ANSWER;
            wait_reg <= 1'b0;
            rdData_reg <= avm_read ? rdValue : 32'h0000_0000;
          end
        end
        rtc_pkg::RTC_BUS_ANSWER: begin
          state_reg <= rtc_pkg::RTC_BUS_IDLE;
          wait_reg <= 1'b1;
        end
        default: state_reg <= rtc_pkg::RTC_BUS_IDLE;
      endcase
    end
  end

  assign avm_waitrequest = wait_reg;
  assign avm_readdata = rdData_reg;

  // writes land on the edge where waitrequest is seen low
  assign wrAcc = avm_write && (state_reg == rtc_pkg::RTC_BUS_ANSWER);

  // byte-lane merge of write data into a stored word
  function automatic logic [31:0] mergeBytes(input logic [31:0] old);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (avm_byteenable[b]) begin
        res[8*b +: 8] = avm_writedata[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // lanes built directly: a function reading bus nets hides them from a continuous assign
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wrMerged[8*b +: 8] = avm_byteenable[b] ? avm_writedata[8*b +: 8] : 8'h00;
  end
  assign loadHit = (avm_address == rtc_pkg::OFF_LOAD1) || (avm_address == rtc_pkg::OFF_LOAD2);
  assign patHit = (avm_address >= rtc_pkg::OFF_PAT0) && (avm_address <= rtc_pkg::OFF_PAT3)
      && (avm_address[1:0] == 2'h0);
  assign clrHit = (wrAcc && avm_address == rtc_pkg::OFF_CLEAR) ? wrMerged[1:0] : 2'h0;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // unmapped or unaligned addresses read zero; clear register reads zero
  always_comb begin
    rdValue = 32'h0000_0000;
    if (avm_address == rtc_pkg::OFF_MASK) begin
      rdValue = {30'h0, mask_reg};
    end else if (avm_address == rtc_pkg::OFF_RAW) begin
      rdValue = {30'h0, raw_reg};
    end else if (avm_address == rtc_pkg::OFF_MASKED) begin
      rdValue = {30'h0, raw_reg & mask_reg};
    end else if (avm_address == rtc_pkg::OFF_DATA) begin
      rdValue = count_reg;
    end else if (avm_address == rtc_pkg::OFF_CTRL) begin
      rdValue = ctl_reg;
    end else if (avm_address == rtc_pkg::OFF_LOAD1) begin
      rdValue = load1_reg;
    end else if (avm_address == rtc_pkg::OFF_LOAD2) begin
      rdValue = load2_reg;
    end else if (patHit) begin
      rdValue = pat_reg[avm_address[3:2] - 2'h3];
    end else if (avm_address == rtc_pkg::OFF_IRQ_NUM) begin
      rdValue = irqNum_reg;
    end
  end

  // ----------------------------------------------------------------
  // interrupt mask, flags and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_reg <= rtc_pkg::IRQ_RST;
    end else if (wrAcc && avm_address == rtc_pkg::OFF_MASK && avm_byteenable[0]) begin
      mask_reg <= avm_writedata[1:0];
    end
  end

  // the event is applied after the clear so it is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      raw_reg <= rtc_pkg::IRQ_RST;
    end else begin
      if (clrHit[rtc_pkg::WATCH_BIT]) begin
        raw_reg[rtc_pkg::WATCH_BIT] <= 1'b0;
      end
      if (clrHit[rtc_pkg::TIMER_BIT]) begin
        raw_reg[rtc_pkg::TIMER_BIT] <= 1'b0;
      end
      if (watchEvent) begin
        raw_reg[rtc_pkg::WATCH_BIT] <= 1'b1;
      end
      if (timerZero) begin
        raw_reg[rtc_pkg::TIMER_BIT] <= 1'b1;
      end
    end
  end

  // outputs lag the flags by one cycle to come straight from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      watchOut_reg <= 1'b0;
      timerOut_reg <= 1'b0;
    end else begin
      watchOut_reg <= raw_reg[rtc_pkg::WATCH_BIT] & mask_reg[rtc_pkg::WATCH_BIT];
      timerOut_reg <= raw_reg[rtc_pkg::TIMER_BIT] & mask_reg[rtc_pkg::TIMER_BIT];
    end
  end

  assign watchIrqOut = watchOut_reg;
  assign timerIrqOut = timerOut_reg;

  // ----------------------------------------------------------------
  // timer control
  // ----------------------------------------------------------------
  assign timerOn = ctl_reg[rtc_pkg::CTL_EN];
  assign timerZero = tickIf.tick && timerOn && (count_reg == 32'h0000_0000);

  // a hardware stop in one-shot mode wins over a same-cycle set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg <= rtc_pkg::CTL_RST;
    end else begin
      if (wrAcc && avm_address == rtc_pkg::OFF_CTRL) begin
        ctl_reg <= mergeBytes(ctl_reg) & rtc_pkg::CTL_WMASK;
      end
      if (wrAcc && loadHit && !timerOn) begin
        ctl_reg[rtc_pkg::CTL_EN] <= 1'b1;
      end
      if (wrAcc && (loadHit || patHit) && ctl_reg[rtc_pkg::CTL_SELF]) begin
        ctl_reg[rtc_pkg::CTL_EN] <= 1'b1;
      end
      if (timerZero && ctl_reg[rtc_pkg::CTL_SHOT]) begin
        ctl_reg[rtc_pkg::CTL_EN] <= 1'b0;
      end
    end
  end

  // load values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load1_reg <= rtc_pkg::LOAD_RST;
      load2_reg <= rtc_pkg::LOAD_RST;
    end else if (wrAcc && avm_address == rtc_pkg::OFF_LOAD1) begin
      load1_reg <= mergeBytes(load1_reg);
    end else if (wrAcc && avm_address == rtc_pkg::OFF_LOAD2) begin
      load2_reg <= mergeBytes(load2_reg);
    end
  end

  // pattern words, lowest pattern bits in the first word
  for (genvar i = 0; i < rtc_pkg::PAT_REGS; i++) begin : g_pat
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pat_reg[i] <= rtc_pkg::LOAD_RST;
      end else if (wrAcc && avm_address == rtc_pkg::OFF_PAT0 + 7'(i) * rtc_pkg::PAT_STEP) begin
        pat_reg[i] <= mergeBytes(pat_reg[i]);
      end
    end
    assign patFlat[32*i +: 32] = pat_reg[i];
  end

  // ----------------------------------------------------------------
  // pattern pointer and counter
  // ----------------------------------------------------------------
  assign patLen = ctl_reg[rtc_pkg::CTL_LEN_HI:rtc_pkg::CTL_LEN_LO];
  // a length of zero or one keeps the pointer on bit zero
  assign ptr_next = ({1'b0, ptr_reg} + 8'h01 >= {1'b0, patLen}) ? 7'h00 : ptr_reg + 7'h01;
  assign reloadValue = patFlat[ptr_reg] ? load2_reg : load1_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_reg <= 7'h00;
    end else if (timerZero && !ctl_reg[rtc_pkg::CTL_SHOT]) begin
      ptr_reg <= ptr_next;
    end
  end

  // one-shot leaves the count parked at zero; a load write while stopped
  // primes the count, otherwise the first run would start from the reset value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= rtc_pkg::DATA_RST;
    end else if (wrAcc && loadHit && !timerOn) begin
      count_reg <= mergeBytes(avm_address == rtc_pkg::OFF_LOAD1 ? load1_reg : load2_reg);
    end else if (timerZero) begin
      if (!ctl_reg[rtc_pkg::CTL_SHOT]) begin
        count_reg <= reloadValue;
      end
    end else if (tickIf.tick && timerOn) begin
      count_reg <= count_reg - 32'h0000_0001;
    end
  end

  // counts timer interrupt events
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqNum_reg <= rtc_pkg::IRQ_NUM_RST;
    end else if (timerZero) begin
      irqNum_reg <= irqNum_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  watch_gate_a: assert property (##1 watchIrqOut == $past(raw_reg[0] & mask_reg[0]))
    else $error("watch output not raw gated by mask");
  timer_gate_a: assert property (##1 timerIrqOut == $past(raw_reg[1] & mask_reg[1]))
    else $error("timer output not raw gated by mask");
  raw_read_a: assert property ((state_reg == rtc_pkg::RTC_BUS_IDLE && avm_read
      && avm_address == rtc_pkg::OFF_RAW) |=> avm_readdata == {30'h0, $past(raw_reg)})
    else $error("raw status read mismatch");
  masked_read_a: assert property ((state_reg == rtc_pkg::RTC_BUS_IDLE && avm_read
      && avm_address == rtc_pkg::OFF_MASKED) |=> avm_readdata[1:0] == $past(raw_reg & mask_reg))
    else $error("masked status read mismatch");
  watch_clear_a: assert property ((clrHit[0] && !watchEvent) |=> !raw_reg[0])
    else $error("watch flag not cleared");
  timer_clear_a: assert property ((clrHit[1] && !timerZero) |=> !raw_reg[1])
    else $error("timer flag not cleared");
  data_reset_a: assert property ($rose(rst_n) |-> count_reg == rtc_pkg::DATA_RST)
    else $error("timer data reset value wrong");
  periodic_reload_a: assert property ((timerZero && !ctl_reg[0])
      |=> count_reg == $past(reloadValue) && raw_reg[1])
    else $error("periodic reload failed");
  one_shot_a: assert property ((timerZero && ctl_reg[0]) |=> !timerOn && raw_reg[1]
      && count_reg == 32'h0000_0000)
    else $error("one-shot did not stop");
  frozen_count_a: assert property ((!timerOn && !(wrAcc && loadHit))
      |=> $stable(count_reg))
    else $error("stopped counter changed");
  load_start_a: assert property ((wrAcc && loadHit && !timerOn && !timerZero)
      |=> timerOn)
    else $error("load write did not start timer");
  load_copy_a: assert property ((wrAcc && loadHit && !timerOn && avm_byteenable == 4'hF)
      |=> count_reg == $past(avm_writedata))
    else $error("load write did not prime the counter");
  self_start_a: assert property ((wrAcc && patHit && ctl_reg[2] && !timerZero)
      |=> timerOn)
    else $error("self-start did not set enable");
  event_wins_a: assert property ((timerZero && clrHit[1]) |=> raw_reg[1])
    else $error("timer event lost to clear");

  periodic_cov: cover property ((timerZero && !ctl_reg[0]) ##[1:1000] timerZero);
  one_shot_cov: cover property (timerZero && ctl_reg[0]);
  clear_race_cov: cover property (watchEvent && clrHit[0]);
  pattern_cov: cover property (timerZero && patFlat[ptr_reg]);
endmodule : rtc_timer_irq_control

/* File: tb.sv */
`timescale 1ns/1ps
// one comparison: counts it, reports a mismatch at once
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb;
  // ----------------------------------------------------------------
  // stimulus signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avm_address = 7'h00;
  logic avm_read = 1'b0;
  logic avm_write = 1'b0;
  logic [31:0] avm_writedata = 32'h0000_0000;
  logic [3:0] avm_byteenable = 4'hF;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic slowRefClock = 1'b0;
  logic trimmedClock = 1'b0;
  logic watchEvent = 1'b0;
  logic watchIrqOut;
  logic timerIrqOut;
  int err_count = 0;
  int n_tests = 0;
  int g0, g1, g2, g3;
  logic [31:0] q;

  rtc_timer_irq_control #(.PAT_BITS(128)) dut (
    .clk(clk),
    .rst_n(rst_n),
    .avm_address(avm_address),
    .avm_read(avm_read),
    .avm_write(avm_write),
    .avm_writedata(avm_writedata),
    .avm_byteenable(avm_byteenable),
    .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest),
    .slowRefClock(slowRefClock),
    .trimmedClock(trimmedClock),
    .watchEvent(watchEvent),
    .watchIrqOut(watchIrqOut),
    .timerIrqOut(timerIrqOut)
  );

  // 200 MHz system clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and pin tasks
  // ----------------------------------------------------------------
  // one bus cycle; request held until waitrequest is sampled low
  task automatic avReq(input logic rd, input logic [6:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] r);
    int n;
    n = 0;
    avm_address <= a;
    avm_writedata <= d;
    avm_byteenable <= be;
    avm_read <= rd;
    avm_write <= !rd;
    do begin
      @(posedge clk);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 100);
    if (avm_waitrequest !== 1'b0) begin
      err_count++;
    end
    r = avm_readdata;
    avm_read <= 1'b0;
    avm_write <= 1'b0;
    // an idle edge keeps the next request from re-driving in this step
    @(posedge clk);
  endtask : avReq

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] r;
    avReq(1'b0, a, d, 4'hF, r);
  endtask : wr

  task automatic rdChk(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] r;
    avReq(1'b1, a, 32'h0000_0000, 4'hF, r);
    `CHK(r, e)
  endtask : rdChk

  // one slow pulse; long phases so the synchroniser and flags settle
  task automatic tick(input bit trim);
    if (trim) trimmedClock <= 1'b1;
    else slowRefClock <= 1'b1;
    repeat (20) @(posedge clk);
    trimmedClock <= 1'b0;
    slowRefClock <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : tick

  // ticks until the timer raw flag shows, counting the ticks taken
  task automatic waitFlag(input bit trim, output int n);
    logic [31:0] r;
    n = 0;
    do begin
      tick(trim);
      n++;
      avReq(1'b1, rtc_pkg::OFF_RAW, 32'h0000_0000, 4'hF, r);
    end while (r[1] !== 1'b1 && n < 40);
    `CHK(r[1], 1'b1)
  endtask : waitFlag

  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  // main sequence: reset values, access kinds, timer modes, interrupts
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(rtc_pkg::OFF_MASK, 32'h0);
    rdChk(rtc_pkg::OFF_RAW, 32'h0);
    rdChk(rtc_pkg::OFF_MASKED, 32'h0);
    rdChk(rtc_pkg::OFF_DATA, rtc_pkg::DATA_RST);
    rdChk(rtc_pkg::OFF_CTRL, rtc_pkg::CTL_RST);
    rdChk(rtc_pkg::OFF_LOAD1, rtc_pkg::LOAD_RST);
    rdChk(rtc_pkg::OFF_LOAD2, rtc_pkg::LOAD_RST);
    rdChk(rtc_pkg::OFF_IRQ_NUM, rtc_pkg::IRQ_NUM_RST);
    rdChk(rtc_pkg::OFF_CLEAR, 32'h0);
    rdChk(7'h50, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdChk(rtc_pkg::OFF_PAT0 + rtc_pkg::PAT_STEP * 7'(i), 32'h0);
    end
    // read-only places ignore writes
    wr(rtc_pkg::OFF_DATA, 32'h1234_5678);
    rdChk(rtc_pkg::OFF_DATA, rtc_pkg::DATA_RST);
    wr(rtc_pkg::OFF_RAW, 32'h0000_0003);
    rdChk(rtc_pkg::OFF_RAW, 32'h0);
    wr(rtc_pkg::OFF_IRQ_NUM, 32'h0000_00FF);
    rdChk(rtc_pkg::OFF_IRQ_NUM, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(rtc_pkg::OFF_PAT0 + rtc_pkg::PAT_STEP * 7'(i), 32'hA500_0000 | i);
    end
    for (int i = 0; i < 4; i++) begin
      rdChk(rtc_pkg::OFF_PAT0 + rtc_pkg::PAT_STEP * 7'(i), 32'hA500_0000 | i);
    end
    // no slow edges arrive here, so enabling all fields is harmless
    wr(rtc_pkg::OFF_CTRL, 32'hFFFF_FFFF);
    rdChk(rtc_pkg::OFF_CTRL, 32'h0000_1FF7);
    wr(rtc_pkg::OFF_CTRL, 32'h0);
    tick(1'b0);
    tick(1'b0);
    rdChk(rtc_pkg::OFF_DATA, rtc_pkg::DATA_RST);
    // pattern write starts the timer only with self-start set
    wr(rtc_pkg::OFF_PAT0, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_CTRL, 32'h0);
    wr(rtc_pkg::OFF_CTRL, 32'h0000_0004);
    wr(rtc_pkg::OFF_PAT0, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_CTRL, 32'h0000_0006);
    // periodic, pattern length 2: reloads alternate load1 and load2
    wr(rtc_pkg::OFF_CTRL, 32'h0000_0020);
    wr(rtc_pkg::OFF_LOAD2, 32'h0000_0005);
    wr(rtc_pkg::OFF_CTRL, 32'h0000_0020);
    wr(rtc_pkg::OFF_LOAD1, 32'h0000_0003);
    rdChk(rtc_pkg::OFF_CTRL, 32'h0000_0022);
    rdChk(rtc_pkg::OFF_LOAD1, 32'h0000_0003);
    rdChk(rtc_pkg::OFF_LOAD2, 32'h0000_0005);
    waitFlag(1'b0, g0);
    rdChk(rtc_pkg::OFF_DATA, 32'h0000_0003);
    wr(rtc_pkg::OFF_CLEAR, 32'h0);
    rdChk(rtc_pkg::OFF_RAW, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_MASKED, 32'h0);
    `CHK(timerIrqOut, 1'b0)
    wr(rtc_pkg::OFF_MASK, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_MASKED, 32'h0000_0002);
    `CHK(timerIrqOut, 1'b1)
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_RAW, 32'h0);
    `CHK(timerIrqOut, 1'b0)
    waitFlag(1'b0, g1);
    rdChk(rtc_pkg::OFF_DATA, 32'h0000_0005);
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0002);
    waitFlag(1'b0, g2);
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0002);
    waitFlag(1'b0, g3);
    `CHK(g2 - g1, 2)
    `CHK(g3, g1)
    rdChk(rtc_pkg::OFF_IRQ_NUM, 32'h0000_0004);
    // clockwatch flag: sticky, masked, cleared only by a one in bit 0
    wr(rtc_pkg::OFF_MASK, 32'h0);
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0002);
    watchEvent <= 1'b1;
    @(posedge clk);
    watchEvent <= 1'b0;
    rdChk(rtc_pkg::OFF_RAW, 32'h0000_0001);
    rdChk(rtc_pkg::OFF_MASKED, 32'h0);
    `CHK(watchIrqOut, 1'b0)
    avReq(1'b0, rtc_pkg::OFF_MASK, 32'h0000_0001, 4'h2, q);
    rdChk(rtc_pkg::OFF_MASK, 32'h0);
    wr(rtc_pkg::OFF_MASK, 32'h0000_0003);
    rdChk(rtc_pkg::OFF_MASKED, 32'h0000_0001);
    `CHK(watchIrqOut, 1'b1)
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_RAW, 32'h0000_0001);
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0001);
    rdChk(rtc_pkg::OFF_RAW, 32'h0);
    `CHK(watchIrqOut, 1'b0)
    // one-shot on the trimmed clock; reference edges must not count
    wr(rtc_pkg::OFF_CTRL, 32'h0000_0821);
    wr(rtc_pkg::OFF_LOAD1, 32'h0000_0002);
    rdChk(rtc_pkg::OFF_CTRL, 32'h0000_0823);
    repeat (8) tick(1'b0);
    rdChk(rtc_pkg::OFF_RAW, 32'h0);
    rdChk(rtc_pkg::OFF_DATA, 32'h0000_0002);
    waitFlag(1'b1, g0);
    rdChk(rtc_pkg::OFF_CTRL, 32'h0000_0821);
    wr(rtc_pkg::OFF_CLEAR, 32'h0000_0002);
    repeat (4) tick(1'b1);
    rdChk(rtc_pkg::OFF_RAW, 32'h0);
    rdChk(rtc_pkg::OFF_DATA, 32'h0);
    end_of_test();
  end

  // watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule : tb
